// File: common/step_timer_pkg.sv
// constants for the compare-match timer and phase port block
// shared by the design; registers sit on a plain byte-wide port
package step_timer_pkg;
	localparam logic [15:0] ADDR_CONTROL      = 16'hF700;
	localparam logic [15:0] ADDR_IO_CONTROL   = 16'hF701;
	localparam logic [15:0] ADDR_STATUS       = 16'hF703;
	localparam logic [15:0] ADDR_IRQ_ENABLE   = 16'hF704;
	localparam logic [15:0] ADDR_COUNT_HI     = 16'hF706;
	localparam logic [15:0] ADDR_COUNT_LO     = 16'hF707;
	localparam logic [15:0] ADDR_CMP_A_HI     = 16'hF708;
	localparam logic [15:0] ADDR_CMP_A_LO     = 16'hF709;
	localparam logic [15:0] ADDR_CMP_B_HI     = 16'hF70A;
	localparam logic [15:0] ADDR_CMP_B_LO     = 16'hF70B;
	localparam logic [15:0] ADDR_RUN          = 16'hF720;
	localparam logic [15:0] ADDR_SYNC         = 16'hF721;
	localparam logic [15:0] ADDR_WAVEFORM     = 16'hF722;
	localparam logic [15:0] ADDR_FUNCTION     = 16'hF723;
	localparam logic [15:0] ADDR_OUT_ENABLE   = 16'hF724;
	localparam logic [15:0] ADDR_OUT_LEVEL    = 16'hF725;
	localparam logic [15:0] ADDR_PORT_DATA    = 16'hFFD9;
	localparam logic [15:0] ADDR_PORT_DIR     = 16'hFFE9;

	localparam int CLEAR_HI = 7;
	localparam int CLEAR_LO = 5;
	localparam int EDGE_HI  = 4;
	localparam int EDGE_LO  = 3;
	localparam int PRESC_HI = 2;
	localparam int PRESC_LO = 0;
	localparam int PIN_B_HI = 6;
	localparam int PIN_B_LO = 4;
	localparam int PIN_A_HI = 2;
	localparam int PIN_A_LO = 0;
	localparam int BIT_B    = 1;
	localparam int BIT_A    = 0;
	localparam int BIT_RUN0 = 0;
	localparam int BIT_RUN1 = 1;
	localparam int BIT_SYNC = 0;
	localparam int BIT_PWMB = 0;
	localparam int CMD_HI   = 1;
	localparam int CMD_LO   = 0;
	localparam int BIT_W    = 3;

	localparam logic [2:0] CLEAR_ON_A   = 3'h1;
	localparam logic [1:0] EDGE_RISING  = 2'h0;
	localparam logic [2:0] PRESC_DIV1   = 3'h0;
	localparam logic [2:0] PRESC_DIV2   = 3'h1;
	localparam logic [2:0] PRESC_DIV4   = 3'h2;
	localparam logic [2:0] PRESC_DIV8   = 3'h3;
	localparam logic [2:0] PIN_NONE     = 3'h0;
	localparam logic [1:0] CMD_NORMAL   = 2'h0;
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [7:0] RST_RUN      = 8'hFC;
	localparam logic [7:0] RST_OUT_EN   = 8'hFF;
	localparam logic [15:0] RST_CMP     = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	localparam logic [15:0] COUNT_ONE   = 16'h0001;
	localparam logic [2:0] PRE_ZERO     = 3'h0;
	localparam logic [2:0] PRE_ONE      = 3'h1;
	localparam logic [3:0] PHASE_MASK   = 4'hF;
endpackage

// File: hw/step_timer.sv
// compare-match timer channel zero plus four-bit phase output port
// assumes a single-cycle byte register port, inputs synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module step_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	output logic             irq,
	output logic             phase_a_output,
	output logic             phase_b_output,
	output logic             phase_a_bar_output,
	output logic             phase_b_bar_output,
	output logic      [3:0]  phase_oe,
	output logic             timer_pin_a,
	output logic             timer_pin_b,
	output logic             timer_pin_a_oe,
	output logic             timer_pin_b_oe
);
	logic [7:0]  timer_control_zero;
	logic [7:0]  timer_io_control_zero;
	logic [1:0]  match_flag;
	logic [7:0]  timer_irq_enable_zero;
	logic [15:0] counter_zero;
	logic [15:0] counter_one;
	logic [15:0] compare_register_a;
	logic [15:0] compare_register_b;
	logic [7:0]  timer_run_control;
	logic [7:0]  timer_sync_mode;
	logic [7:0]  timer_waveform_mode;
	logic [7:0]  timer_function_control;
	logic [7:0]  timer_output_master_enable;
	logic [7:0]  timer_output_initial_level;
	logic [7:0]  phase_port_data;
	logic [7:0]  phase_port_direction;
	logic [2:0]  prescale;
	logic        tick;
	logic        run0;
	logic        run1;
	logic        match_a;
	logic        match_b;
	logic        rd_status;
	logic [1:0]  status_seen;

	// prescaler divider; tick is the rising edge of the selected clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			prescale <= step_timer_pkg::PRE_ZERO;
		else
			prescale <= prescale + step_timer_pkg::PRE_ONE;
	end

	always_comb begin
		case (timer_control_zero[step_timer_pkg::PRESC_HI:step_timer_pkg::PRESC_LO])
			step_timer_pkg::PRESC_DIV1: tick = 1'b1;
			step_timer_pkg::PRESC_DIV2: tick = prescale[0];
			step_timer_pkg::PRESC_DIV4: tick = &prescale[1:0];
			step_timer_pkg::PRESC_DIV8: tick = &prescale;
			default:                    tick = &prescale;
		endcase
	end

	// sync ties both counters to either run bit
	always_comb begin
		run0 = timer_run_control[step_timer_pkg::BIT_RUN0];
		run1 = timer_run_control[step_timer_pkg::BIT_RUN1];
		if (timer_sync_mode[step_timer_pkg::BIT_SYNC]) begin
			run0 = run0 | run1;
			run1 = run0;
		end
	end

	assign match_a = (counter_zero == compare_register_a) & run0 & tick;
	assign match_b = (counter_zero == compare_register_b) & run0 & tick;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			counter_zero <= step_timer_pkg::COUNT_ZERO;
		else if (wr && addr == step_timer_pkg::ADDR_COUNT_HI)
			counter_zero <= {wdata, counter_zero[7:0]};
		else if (wr && addr == step_timer_pkg::ADDR_COUNT_LO)
			counter_zero <= {counter_zero[15:8], wdata};
		else if (match_a && timer_control_zero[step_timer_pkg::CLEAR_HI:step_timer_pkg::CLEAR_LO]
				== step_timer_pkg::CLEAR_ON_A)
			counter_zero <= step_timer_pkg::COUNT_ZERO;
		else if (run0 && tick && timer_control_zero[step_timer_pkg::EDGE_HI:step_timer_pkg::EDGE_LO]
				== step_timer_pkg::EDGE_RISING)
			counter_zero <= counter_zero + step_timer_pkg::COUNT_ONE;
	end

	// counter one follows in lockstep when synced
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			counter_one <= step_timer_pkg::COUNT_ZERO;
		else if (timer_sync_mode[step_timer_pkg::BIT_SYNC] && run1 && tick)
			counter_one <= counter_zero + step_timer_pkg::COUNT_ONE;
		else if (run1 && tick)
			counter_one <= counter_one + step_timer_pkg::COUNT_ONE;
	end

	// flags set by match, cleared by write 0 after read; set wins
	assign rd_status = rd && addr == step_timer_pkg::ADDR_STATUS;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			status_seen <= 2'h0;
		else if (rd_status)
			status_seen <= match_flag;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			match_flag <= 2'h0;
		else begin
			if (match_b)
				match_flag[step_timer_pkg::BIT_B] <= 1'b1;
			else if (wr && addr == step_timer_pkg::ADDR_STATUS
					&& !wdata[step_timer_pkg::BIT_B] && status_seen[step_timer_pkg::BIT_B])
				match_flag[step_timer_pkg::BIT_B] <= 1'b0;
			if (match_a)
				match_flag[step_timer_pkg::BIT_A] <= 1'b1;
			else if (wr && addr == step_timer_pkg::ADDR_STATUS
					&& !wdata[step_timer_pkg::BIT_A] && status_seen[step_timer_pkg::BIT_A])
				match_flag[step_timer_pkg::BIT_A] <= 1'b0;
		end
	end

	// flags gated by enables in output compare mode
	// pin control zero keeps output compare
	always_comb begin
		irq = 1'b0;
		if (!timer_io_control_zero[step_timer_pkg::PIN_A_HI]
				&& timer_irq_enable_zero[step_timer_pkg::BIT_A] && match_flag[step_timer_pkg::BIT_A])
			irq = 1'b1;
		if (!timer_io_control_zero[step_timer_pkg::PIN_B_HI]
				&& timer_irq_enable_zero[step_timer_pkg::BIT_B] && match_flag[step_timer_pkg::BIT_B])
			irq = 1'b1;
	end

	// control register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_control_zero         <= step_timer_pkg::RST_BYTE;
			timer_io_control_zero      <= step_timer_pkg::RST_BYTE;
			timer_irq_enable_zero      <= step_timer_pkg::RST_BYTE;
			compare_register_a         <= step_timer_pkg::RST_CMP;
			compare_register_b         <= step_timer_pkg::RST_CMP;
			timer_run_control          <= step_timer_pkg::RST_RUN;
			timer_sync_mode            <= step_timer_pkg::RST_BYTE;
			timer_waveform_mode        <= step_timer_pkg::RST_BYTE;
			timer_function_control     <= step_timer_pkg::RST_BYTE;
			timer_output_master_enable <= step_timer_pkg::RST_OUT_EN;
			timer_output_initial_level <= step_timer_pkg::RST_BYTE;
			phase_port_data            <= step_timer_pkg::RST_BYTE;
			phase_port_direction       <= step_timer_pkg::RST_BYTE;
		end else if (wr) begin
			if (addr == step_timer_pkg::ADDR_CONTROL)
				timer_control_zero <= wdata;
			else if (addr == step_timer_pkg::ADDR_IO_CONTROL)
				timer_io_control_zero <= wdata & 8'h77;
			else if (addr == step_timer_pkg::ADDR_IRQ_ENABLE)
				timer_irq_enable_zero <= wdata;
			else if (addr == step_timer_pkg::ADDR_CMP_A_HI)
				compare_register_a <= {wdata, compare_register_a[7:0]};
			else if (addr == step_timer_pkg::ADDR_CMP_A_LO)
				compare_register_a <= {compare_register_a[15:8], wdata};
			else if (addr == step_timer_pkg::ADDR_CMP_B_HI)
				compare_register_b <= {wdata, compare_register_b[7:0]};
			else if (addr == step_timer_pkg::ADDR_CMP_B_LO)
				compare_register_b <= {compare_register_b[15:8], wdata};
			else if (addr == step_timer_pkg::ADDR_RUN)
				timer_run_control <= wdata;
			else if (addr == step_timer_pkg::ADDR_SYNC)
				timer_sync_mode <= wdata;
			else if (addr == step_timer_pkg::ADDR_WAVEFORM)
				timer_waveform_mode <= wdata;
			else if (addr == step_timer_pkg::ADDR_FUNCTION)
				timer_function_control <= wdata;
			else if (addr == step_timer_pkg::ADDR_OUT_ENABLE)
				timer_output_master_enable <= wdata;
			else if (addr == step_timer_pkg::ADDR_OUT_LEVEL)
				timer_output_initial_level <= wdata;
			else if (addr == step_timer_pkg::ADDR_PORT_DATA)
				phase_port_data <= wdata;
			else if (addr == step_timer_pkg::ADDR_PORT_DIR)
				phase_port_direction <= wdata;
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= step_timer_pkg::RST_BYTE;
		else if (!rd)
			rdata <= step_timer_pkg::RST_BYTE;
		else if (addr == step_timer_pkg::ADDR_CONTROL)
			rdata <= timer_control_zero;
		else if (addr == step_timer_pkg::ADDR_IO_CONTROL)
			rdata <= timer_io_control_zero;
		else if (addr == step_timer_pkg::ADDR_STATUS)
			rdata <= {6'h00, match_flag};
		else if (addr == step_timer_pkg::ADDR_IRQ_ENABLE)
			rdata <= timer_irq_enable_zero;
		else if (addr == step_timer_pkg::ADDR_COUNT_HI)
			rdata <= counter_zero[15:8];
		else if (addr == step_timer_pkg::ADDR_COUNT_LO)
			rdata <= counter_zero[7:0];
		else if (addr == step_timer_pkg::ADDR_CMP_A_HI)
			rdata <= compare_register_a[15:8];
		else if (addr == step_timer_pkg::ADDR_CMP_A_LO)
			rdata <= compare_register_a[7:0];
		else if (addr == step_timer_pkg::ADDR_CMP_B_HI)
			rdata <= compare_register_b[15:8];
		else if (addr == step_timer_pkg::ADDR_CMP_B_LO)
			rdata <= compare_register_b[7:0];
		else if (addr == step_timer_pkg::ADDR_RUN)
			rdata <= timer_run_control;
		else if (addr == step_timer_pkg::ADDR_SYNC)
			rdata <= timer_sync_mode;
		else if (addr == step_timer_pkg::ADDR_WAVEFORM)
			rdata <= timer_waveform_mode;
		else if (addr == step_timer_pkg::ADDR_FUNCTION)
			rdata <= timer_function_control;
		else if (addr == step_timer_pkg::ADDR_OUT_ENABLE)
			rdata <= timer_output_master_enable;
		else if (addr == step_timer_pkg::ADDR_OUT_LEVEL)
			rdata <= timer_output_initial_level;
		else if (addr == step_timer_pkg::ADDR_PORT_DATA)
			rdata <= phase_port_data;
		else if (addr == step_timer_pkg::ADDR_PORT_DIR)
			rdata <= phase_port_direction;
		else
			rdata <= step_timer_pkg::RST_BYTE;
	end

	// bit three A, two B, one A-bar, zero B-bar
	assign phase_a_output     = phase_port_data[3];
	assign phase_b_output     = phase_port_data[2];
	assign phase_a_bar_output = phase_port_data[1];
	assign phase_b_bar_output = phase_port_data[0];

	// direction bits enable each phase driver
	generate
		for (genvar i = 0; i <= step_timer_pkg::BIT_W; i++) begin : g_dir
			assign phase_oe[i] = phase_port_direction[i];
		end
	endgenerate

	// initial levels drive the timer pins
	// waveform mode bit zero only gates pin B enable; pins carry no compare action
	assign timer_pin_a = timer_output_initial_level[step_timer_pkg::BIT_A];
	assign timer_pin_b = timer_output_initial_level[step_timer_pkg::BIT_B];

	// normal mode only; other combine modes disable pins
	assign timer_pin_a_oe = !timer_output_master_enable[step_timer_pkg::BIT_A]
		&& timer_function_control[step_timer_pkg::CMD_HI:step_timer_pkg::CMD_LO]
		== step_timer_pkg::CMD_NORMAL;
	assign timer_pin_b_oe = !timer_output_master_enable[step_timer_pkg::BIT_B]
		&& timer_function_control[step_timer_pkg::CMD_HI:step_timer_pkg::CMD_LO]
		== step_timer_pkg::CMD_NORMAL
		&& !timer_waveform_mode[step_timer_pkg::BIT_PWMB];

	property p_clear_on_a;
		@(posedge sys_clk) disable iff (!rst_n)
		(match_a && timer_control_zero[7:5] == 3'h1 && !wr) |=> counter_zero == 16'h0000;
	endproperty
	a_clear_on_a: assert property (p_clear_on_a) else $error("counter not cleared on match");

	property p_div8;
		@(posedge sys_clk) disable iff (!rst_n)
		(timer_control_zero[2:0] == 3'h3 && tick) |=> !tick [*7] ##1 tick;
	endproperty
	a_div8: assert property (p_div8) else $error("tick spacing wrong");

	property p_stop_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(!run0 && !wr) |=> $stable(counter_zero);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

	property p_increment;
		@(posedge sys_clk) disable iff (!rst_n)
		(run0 && tick && !match_a && !wr && timer_control_zero[4:3] == 2'h0)
			|=> counter_zero == $past(counter_zero) + 16'h0001;
	endproperty
	a_increment: assert property (p_increment) else $error("counter did not increment");

	property p_flag_b;
		@(posedge sys_clk) disable iff (!rst_n)
		match_b |=> match_flag[1];
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("flag B not set");

	property p_match_eq;
		@(posedge sys_clk) disable iff (!rst_n)
		match_a |-> counter_zero == compare_register_a;
	endproperty
	a_match_eq: assert property (p_match_eq) else $error("match without equality");

	property p_irq;
		@(posedge sys_clk) disable iff (!rst_n)
		(match_flag[0] && timer_irq_enable_zero[0] && !timer_io_control_zero[2]) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	property p_pin_off;
		@(posedge sys_clk) disable iff (!rst_n)
		timer_output_master_enable[0] |-> !timer_pin_a_oe;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin A driven while disabled");
endmodule
`default_nettype wire

// File: verif/motor_driver_model.sv
// driver stage model: watches the four phase lines and their drive enables
// assumes the phase lines come straight from the timer block's port register
`timescale 1ns/1ps
`default_nettype none
module motor_driver_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       phase_a,
	input  wire logic       phase_b,
	input  wire logic       phase_a_bar,
	input  wire logic       phase_b_bar,
	input  wire logic [3:0] phase_oe,
	output int              steps,
	output int              faults
);
	logic [3:0] pattern [8] = '{4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
	logic [3:0] now;
	logic [3:0] last;
	int         pos;
	logic       started;
	assign now = {phase_a, phase_b, phase_a_bar, phase_b_bar};
	// one step either way, first pattern phase A only
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			steps <= 0;
			faults <= 0;
			pos <= 0;
			started <= 1'b0;
			last <= 4'h0;
		end else if (phase_oe === 4'hF && now !== last) begin
			last <= now;
			steps <= steps + 1;
			started <= 1'b1;
			if (!started) begin
				if (now !== pattern[0])
					faults <= faults + 1;
			end else if (now === pattern[(pos + 1) % 8])
				pos <= (pos + 1) % 8;
			else if (now === pattern[(pos + 7) % 8])
				pos <= (pos + 7) % 8;
			else
				faults <= faults + 1;
		end
	end
endmodule
`default_nettype wire

// File: verif/stepper_two_phase_timer_drive_bench.sv
// self-checking bench for the timer channel and phase port
// assumes the single-cycle register port and a driver stage on the phase lines
`timescale 1ns/1ps
`default_nettype none
module stepper_two_phase_timer_drive_bench;
	logic        sys_clk, rst_n, wr, rd, rd_seen, irq;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata;
	logic        ph_a, ph_b, ph_ab, ph_bb, pin_a, pin_b, pin_a_oe, pin_b_oe;
	logic [3:0]  phase_oe;
	logic [7:0]  expect_q [$];
	logic [7:0]  pat [8] = '{8'h08, 8'h0C, 8'h04, 8'h06, 8'h02, 8'h03, 8'h01, 8'h09};
	int          n_errors = 0, total_checks = 0, cyc = 0, seed = 54;
	int          steps, faults, t0, t1, period;

	step_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .phase_a_output(ph_a), .phase_b_output(ph_b),
		.phase_a_bar_output(ph_ab), .phase_b_bar_output(ph_bb), .phase_oe(phase_oe),
		.timer_pin_a(pin_a), .timer_pin_b(pin_b), .timer_pin_a_oe(pin_a_oe),
		.timer_pin_b_oe(pin_b_oe));
	motor_driver_model drv (.sys_clk(sys_clk), .rst_n(rst_n), .phase_a(ph_a), .phase_b(ph_b),
		.phase_a_bar(ph_ab), .phase_b_bar(ph_bb), .phase_oe(phase_oe), .steps(steps),
		.faults(faults));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic complete_run;
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic check_int(input string name, input int e, input int g);
		total_checks++;
		if (g != e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", name, e, g);
		end
	endtask
	task automatic put(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic get(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		expect_q.push_back(e);
		@(posedge sys_clk);
		rd <= 1'b0;
	endtask
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check_int("irq wait", 1, int'(n < 400));
		t = cyc;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen === 1'b1 && expect_q.size() > 0)
			check_byte("rdata", expect_q.pop_front(), rdata);
		rd_seen <= rd;
	end

	initial begin
		#(50 * 6000);
		n_errors++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		rd_seen = 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		get(step_timer_pkg::ADDR_RUN, 8'hFC);
		get(step_timer_pkg::ADDR_OUT_ENABLE, 8'hFF);
		get(step_timer_pkg::ADDR_CMP_A_HI, 8'hFF);
		get(step_timer_pkg::ADDR_SYNC, 8'h00);
		put(16'hF702, 8'($random(seed)));
		get(16'hF702, 8'h00);
		get(step_timer_pkg::ADDR_STATUS, 8'h00);
		put(step_timer_pkg::ADDR_IO_CONTROL, 8'hFF);
		get(step_timer_pkg::ADDR_IO_CONTROL, 8'h77);
		put(step_timer_pkg::ADDR_IO_CONTROL, 8'h00);
		put(step_timer_pkg::ADDR_CONTROL, 8'h23);
		get(step_timer_pkg::ADDR_CONTROL, 8'h23);
		put(step_timer_pkg::ADDR_IRQ_ENABLE, 8'h03);
		put(step_timer_pkg::ADDR_CMP_A_HI, 8'h00);
		put(step_timer_pkg::ADDR_CMP_A_LO, 8'h04);
		put(step_timer_pkg::ADDR_CMP_B_HI, 8'h00);
		put(step_timer_pkg::ADDR_CMP_B_LO, 8'h02);
		put(step_timer_pkg::ADDR_COUNT_HI, 8'h00);
		put(step_timer_pkg::ADDR_COUNT_LO, 8'h03);
		put(step_timer_pkg::ADDR_PORT_DIR, 8'h0F);
		put(step_timer_pkg::ADDR_PORT_DATA, 8'h08);
		#1;
		check_byte("phase", 8'hF8, {phase_oe, ph_a, ph_b, ph_ab, ph_bb});
		put(step_timer_pkg::ADDR_RUN, 8'h01);
		period = 4;
		t0 = 0;
		for (int i = 1; i <= 8; i++) begin
			wait_irq(t1);
			if (i > 1)
				check_int("gap", i % 2 == 1 ? (period - 2) * 8 : 24, t1 - t0);
			get(step_timer_pkg::ADDR_STATUS, i % 2 == 1 ? 8'h01 : 8'h02);
			put(step_timer_pkg::ADDR_PORT_DATA, pat[i % 8]);
			if (i % 2 == 1) begin
				period = 7 - (i / 2);
				put(step_timer_pkg::ADDR_CMP_A_LO, period[7:0]);
			end
			put(step_timer_pkg::ADDR_STATUS, i % 2 == 1 ? 8'hFE : 8'hFD);
			#1;
			check_byte("irq", 8'h00, {7'h00, irq});
			t0 = t1;
		end
		put(step_timer_pkg::ADDR_IRQ_ENABLE, 8'h00);
		repeat (80) @(posedge sys_clk);
		#1;
		check_byte("irq", 8'h00, {7'h00, irq});
		check_byte("phase", 8'hF8, {phase_oe, ph_a, ph_b, ph_ab, ph_bb});
		for (int j = 7; j >= 4; j--)
			put(step_timer_pkg::ADDR_PORT_DATA, pat[j]);
		put(step_timer_pkg::ADDR_RUN, 8'h00);
		put(step_timer_pkg::ADDR_COUNT_LO, 8'h00);
		repeat (40) @(posedge sys_clk);
		check_byte("phase", 8'hF2, {phase_oe, ph_a, ph_b, ph_ab, ph_bb});
		get(step_timer_pkg::ADDR_COUNT_LO, 8'h00);
		get(step_timer_pkg::ADDR_STATUS, 8'h03);
		put(step_timer_pkg::ADDR_IRQ_ENABLE, 8'h02);
		#1;
		check_byte("irq", 8'h01, {7'h00, irq});
		put(step_timer_pkg::ADDR_STATUS, 8'h00);
		#1;
		check_byte("irq", 8'h00, {7'h00, irq});
		put(step_timer_pkg::ADDR_OUT_LEVEL, 8'h02);
		put(step_timer_pkg::ADDR_OUT_ENABLE, 8'hFC);
		#1;
		check_byte("pins", 8'h0D, {4'h0, pin_a_oe, pin_b_oe, pin_a, pin_b});
		put(step_timer_pkg::ADDR_WAVEFORM, 8'h01);
		#1;
		check_byte("pins", 8'h09, {4'h0, pin_a_oe, pin_b_oe, pin_a, pin_b});
		put(step_timer_pkg::ADDR_FUNCTION, 8'h01);
		#1;
		check_byte("pins", 8'h01, {4'h0, pin_a_oe, pin_b_oe, pin_a, pin_b});
		check_int("steps", 13, steps);
		check_int("faults", 0, faults);
		complete_run();
	end
endmodule
`default_nettype wire
